// ---- pkg/lsf_params.svh ----
// Constants for the link sub-block formatter: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the design and the bench.
`ifndef LSF_PARAMS_SVH
`define LSF_PARAMS_SVH
`define LSF_A_CTRL 8'h00
`define LSF_A_ID 8'h04
`define LSF_A_PLEN 8'h08
`define LSF_A_SUBS 8'h0C
`define LSF_A_STAT 8'h10
`define LSF_CTRL_RST 12'hC01
`define LSF_ID_RST 25'h0400001
`define LSF_PLEN_RST 8'h04
`define LSF_TAG_HDR 4'hC
`define LSF_TAG_MHDR 4'hE
`define LSF_FMT_NEUT 3'h0
`define LSF_FMT_ZS 3'h1
`define LSF_F_GP 0
`define LSF_F_GI 1
`define LSF_F_BM 2
`define LSF_F_DFO 3
`define LSF_F_MSE 4
`define LSF_F_GD 5
`define LSF_F_GT 6
`define LSF_TIMEOUT_NS 10000
`define LSF_CLK_NS 40
`define LSF_TIMEOUT_CYC (`LSF_TIMEOUT_NS / `LSF_CLK_NS)
`endif

// ---- pkg/lsf_pkg.sv ----
// Types for the link sub-block formatter.
// Assumes nothing of its surroundings.
package lsf_pkg;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_WAIT = 4'h2,
		ST_DATA = 4'h4,
		ST_STAT = 4'h8
	} lsf_state_e;
	typedef enum logic [3:0] {
		CAT_NEUT = 4'h0,
		CAT_PPM = 4'h1,
		CAT_CPT = 4'h2,
		CAT_CPH = 4'h3,
		CAT_MRG = 4'h4,
		CAT_JET = 4'h5,
		CAT_JETET = 4'h6,
		CAT_EX = 4'h7,
		CAT_EY = 4'h8,
		CAT_SUM = 4'h9
	} lsf_cat_e;
endpackage

// ---- rtl/lsf_formatter.sv ----
// Link sub-block formatter: serial link ticks to 32-bit sub-blocks.
// Assumes an AHB-Lite master on hclk and link pins from another clock.
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "lsf_params.svh"

module lsf_formatter #(
	parameter int TIMEOUT_CYC = `LSF_TIMEOUT_CYC
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Serial link pins
	input wire logic [19:0] link_data,
	input wire logic link_data_valid_n,
	input wire logic link_ready,
	input wire logic tick_protocol_err,
	// Trigger side, same clock
	input wire logic trigger_accept,
	input wire logic [11:0] bunch_number,
	input wire logic readout_fifo_overflow,
	input wire logic module_specific_err,
	// Sub-block output
	output logic [31:0] out_word,
	output logic out_valid
);
	logic [19:0] d1_r, d2_r;
	logic [2:0] c1_r, c2_r;
	logic pend_r, pwr_r;
	logic [7:0] paddr_r;
	logic [31:0] hrdata_r;
	logic hready_r;
	logic [11:0] ctrl_r;
	logic [24:0] id_r;
	logic [7:0] plen_r;
	logic [31:0] subs_r;
	logic [4:0] emap_r;
	logic pfail_r;
	lsf_pkg::lsf_state_e state_r;
	logic [2:0] slice_r;
	logic [7:0] idx_r;
	logic [19:0] par_r;
	logic [6:0] flags_r, fl_c;
	logic [5:0] bcnf_r;
	logic [15:0] tmr_r;
	logic [31:0] word_r;
	logic valid_r;
	logic [1:0] kind_r;

	// Two-stage pin synchronisers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			d1_r <= 20'h00000;
			d2_r <= 20'h00000;
			c1_r <= 3'h4;
			c2_r <= 3'h4;
		end else begin
			d1_r <= link_data;
			d2_r <= d1_r;
			c1_r <= {link_data_valid_n, link_ready, tick_protocol_err};
			c2_r <= c1_r;
		end
	end

	logic tick, rdy, perr, neut, w20, last;
	logic [19:0] td;
	logic [3:0] htag;
	logic [5:0] seqno;
	lsf_pkg::lsf_cat_e cat;
	assign tick = !c2_r[2];
	assign rdy = c2_r[1];
	assign perr = c2_r[0];
	assign neut = ctrl_r[2:0] == `LSF_FMT_NEUT;
	assign w20 = ctrl_r[3];
	assign cat = lsf_pkg::lsf_cat_e'(ctrl_r[7:4]);
	assign td = w20 ? d2_r : {4'h0, d2_r[15:0]};
	assign htag = neut ? (ctrl_r[11:8] & 4'hE) : (cat == lsf_pkg::CAT_MRG ? `LSF_TAG_MHDR : `LSF_TAG_HDR);
	assign seqno = (cat == lsf_pkg::CAT_PPM) ? id_r[21:16] : {3'h0, slice_r};
	assign last = neut || ({1'b0, slice_r} + 4'h1 >= {1'b0, id_r[10:8]});

	function automatic logic [31:0] pay_word(lsf_pkg::lsf_cat_e c, logic [19:0] d);
		begin
			case (c)
				lsf_pkg::CAT_PPM: pay_word = {1'b0, 11'h000, d};
				lsf_pkg::CAT_CPT: pay_word = {2'b01, 10'h000, d};
				lsf_pkg::CAT_CPH: pay_word = {2'b10, 10'h000, d};
				lsf_pkg::CAT_JET: pay_word = {3'b100, 9'h000, d};
				lsf_pkg::CAT_JETET: pay_word = {3'b101, 9'h000, d};
				lsf_pkg::CAT_EX: pay_word = {4'b0100, 8'h00, d};
				lsf_pkg::CAT_EY: pay_word = {4'b0110, 8'h00, d};
				lsf_pkg::CAT_SUM: pay_word = {4'b0101, 8'h00, d};
				default: pay_word = {2'b00, 10'h000, d};
			endcase
		end
	endfunction

	function automatic logic [4:0] low_pin(logic [19:0] v);
		begin
			low_pin = 5'h00;
			for (int i = 19; i >= 0; i--) begin
				if (v[i]) begin
					low_pin = 5'(i);
				end
			end
		end
	endfunction

	logic [31:0] hdr_w, stat_w;
	logic par_tick, par_bad;
	assign par_tick = state_r == lsf_pkg::ST_DATA && !neut && tick && idx_r == plen_r;
	assign par_bad = |(par_r ^ td);
	assign hdr_w = {htag, id_r[24:22], ctrl_r[2:0], seqno, id_r[7:4], id_r[3:0], id_r[15:11], id_r[10:8]};
	assign stat_w = {htag | 4'h1, bcnf_r, seqno, id_r[7:4], id_r[3:0], 1'b0, fl_c};

	// Error flags for the current slice
	always_comb begin
		fl_c = flags_r;
		if (state_r != lsf_pkg::ST_IDLE && !rdy) begin
			fl_c[`LSF_F_GD] = 1'b1;
		end
		if (tick && perr && state_r != lsf_pkg::ST_IDLE) begin
			fl_c[`LSF_F_GI] = 1'b1;
		end
		if (state_r != lsf_pkg::ST_IDLE) begin
			fl_c[`LSF_F_DFO] = flags_r[`LSF_F_DFO] | readout_fifo_overflow;
			fl_c[`LSF_F_MSE] = flags_r[`LSF_F_MSE] | module_specific_err;
		end
		if (par_tick && par_bad) begin
			fl_c[`LSF_F_GP] = 1'b1;
		end
		if (neut) begin
			fl_c[`LSF_F_GP] = 1'b0;
			fl_c[`LSF_F_BM] = 1'b0;
		end
	end

	// AHB-Lite slave, one wait state per transfer
	logic take;
	assign take = hsel && htrans[1] && hready;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_r <= 1'b0;
			pwr_r <= 1'b0;
			paddr_r <= 8'h00;
			hready_r <= 1'b1;
		end else begin
			pend_r <= take;
			hready_r <= !take;
			if (take) begin
				pwr_r <= hwrite && hsize == 3'h2 && haddr[31:8] == 24'h000000;
				paddr_r <= haddr[7:0];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_r <= 32'h00000000;
		end else if (pend_r) begin
			case (paddr_r)
				`LSF_A_CTRL: hrdata_r <= {20'h00000, ctrl_r};
				`LSF_A_ID: hrdata_r <= {7'h00, id_r};
				`LSF_A_PLEN: hrdata_r <= {24'h000000, plen_r};
				`LSF_A_SUBS: hrdata_r <= subs_r;
				`LSF_A_STAT: hrdata_r <= {24'h000000, 1'b0, state_r == lsf_pkg::ST_IDLE, pfail_r, emap_r};
				default: hrdata_r <= 32'h00000000;
			endcase
		end
	end

	logic wr;
	assign wr = pend_r && pwr_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r <= `LSF_CTRL_RST;
			id_r <= `LSF_ID_RST;
			plen_r <= `LSF_PLEN_RST;
			subs_r <= 32'h00000000;
		end else if (wr) begin
			case (paddr_r)
				`LSF_A_CTRL: ctrl_r <= hwdata[11:0];
				`LSF_A_ID: id_r <= hwdata[24:0];
				`LSF_A_PLEN: plen_r <= hwdata[7:0];
				`LSF_A_SUBS: subs_r <= hwdata;
				default: ;
			endcase
		end
	end

	// Error map: a write to STAT clears, a new failure wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			emap_r <= 5'h00;
			pfail_r <= 1'b0;
		end else if (par_tick && par_bad) begin
			emap_r <= low_pin(par_r ^ td);
			pfail_r <= 1'b1;
		end else if (wr && paddr_r == `LSF_A_STAT) begin
			emap_r <= 5'h00;
			pfail_r <= 1'b0;
		end
	end

	// Sub-block sequencer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= lsf_pkg::ST_IDLE;
			slice_r <= 3'h0;
			idx_r <= 8'h00;
			par_r <= 20'h00000;
			flags_r <= 7'h00;
			bcnf_r <= 6'h00;
			tmr_r <= 16'h0000;
			word_r <= 32'h00000000;
			valid_r <= 1'b0;
			kind_r <= 2'h0;
		end else begin
			valid_r <= 1'b0;
			if (state_r != lsf_pkg::ST_IDLE) begin
				flags_r <= fl_c;
			end
			case (state_r)
				lsf_pkg::ST_IDLE: begin
					slice_r <= 3'h0;
					flags_r <= 7'h00;
					bcnf_r <= 6'h00;
					tmr_r <= 16'h0000;
					if (trigger_accept) begin
						state_r <= lsf_pkg::ST_WAIT;
						if (neut) begin
							word_r <= hdr_w;
							valid_r <= 1'b1;
							kind_r <= 2'h1;
						end
					end
				end
				lsf_pkg::ST_WAIT: begin
					tmr_r <= tmr_r + 16'h0001;
					if (tick) begin
						state_r <= lsf_pkg::ST_DATA;
						idx_r <= 8'h00;
						valid_r <= 1'b1;
						if (neut) begin
							word_r <= {2'b00, 7'h00, tick, !rdy, perr, td};
							kind_r <= 2'h0;
						end else begin
							word_r <= hdr_w;
							kind_r <= 2'h1;
							par_r <= td;
							if (td[11:0] != bunch_number) begin
								flags_r[`LSF_F_BM] <= 1'b1;
								flags_r[`LSF_F_GD] <= fl_c[`LSF_F_GD];
								bcnf_r <= td[5:0];
							end
						end
					end else if (tmr_r == 16'(TIMEOUT_CYC - 1)) begin
						flags_r[`LSF_F_GT] <= 1'b1;
						state_r <= lsf_pkg::ST_STAT;
						if (!neut) begin
							word_r <= hdr_w;
							valid_r <= 1'b1;
							kind_r <= 2'h1;
						end
					end
				end
				lsf_pkg::ST_DATA: begin
					if (neut) begin
						if (tick) begin
							word_r <= {2'b00, 7'h00, tick, !rdy, perr, td};
							valid_r <= 1'b1;
							kind_r <= 2'h0;
						end else begin
							valid_r <= |fl_c;
							word_r <= stat_w;
							kind_r <= 2'h2;
							state_r <= lsf_pkg::ST_IDLE;
						end
					end else if (tick) begin
						if (idx_r != plen_r) begin
							par_r <= par_r ^ td;
							idx_r <= idx_r + 8'h01;
							word_r <= pay_word(cat, td);
							kind_r <= 2'h0;
							valid_r <= td != 20'h00000 && !subs_r[idx_r[4:0]];
						end else begin
							valid_r <= |fl_c;
							word_r <= stat_w;
							kind_r <= 2'h2;
							flags_r <= 7'h00;
							bcnf_r <= 6'h00;
							tmr_r <= 16'h0000;
							slice_r <= slice_r + 3'h1;
							state_r <= last ? lsf_pkg::ST_IDLE : lsf_pkg::ST_WAIT;
						end
					end
				end
				lsf_pkg::ST_STAT: begin
					valid_r <= 1'b1;
					word_r <= stat_w;
					kind_r <= 2'h2;
					state_r <= lsf_pkg::ST_IDLE;
				end
				default: state_r <= lsf_pkg::ST_IDLE;
			endcase
		end
	end

	assign hrdata = hrdata_r;
	assign hreadyout = hready_r;
	assign hresp = 1'b0;
	assign out_word = word_r;
	assign out_valid = valid_r;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_hdr_tag_even: assert property (valid_r && kind_r == 2'h1 |-> !word_r[28])
		else $error("header tag does not end in 0");
	a_stat_tag_odd: assert property (valid_r && kind_r == 2'h2 |-> word_r[28])
		else $error("status tag does not end in 1");
	a_stat_only_err: assert property (valid_r && kind_r == 2'h2 |-> |word_r[6:0])
		else $error("status word sent without error");
	a_hdr_ids_reg: assert property (valid_r && kind_r == 2'h1 |-> word_r[15:8] == $past(id_r[7:0]))
		else $error("header ids not from register");
	a_neut_no_bm: assert property ($past(neut) && valid_r && kind_r == 2'h2 |-> word_r[2] == 1'b0 && !word_r[0])
		else $error("neutral status shows parity or bunch error");
	a_neut_zero_ext: assert property (state_r == lsf_pkg::ST_DATA && neut && tick && !w20
		|=> word_r[19:16] == 4'h0 && word_r[22])
		else $error("neutral narrow data not zero-extended");
	a_zs_nonzero: assert property (!$past(neut) && valid_r && kind_r == 2'h0 |-> word_r[19:0] != 20'h00000)
		else $error("zero payload word emitted");
	a_bunch_check: assert property (state_r == lsf_pkg::ST_WAIT && tick && !neut && td[11:0] != bunch_number
		|=> flags_r[`LSF_F_BM] && bcnf_r == $past(td[5:0]))
		else $error("bunch mismatch not recorded");
	a_parity_report: assert property (par_tick && par_bad
		|=> valid_r && kind_r == 2'h2 && word_r[0] && pfail_r)
		else $error("parity failure not reported");
	a_timeout_stat: assert property (state_r == lsf_pkg::ST_WAIT && !tick && tmr_r == 16'(TIMEOUT_CYC - 1)
		|=> state_r == lsf_pkg::ST_STAT ##1 valid_r && kind_r == 2'h2 && word_r[6])
		else $error("timeout status missing");
	a_hdr_opens: assert property (state_r == lsf_pkg::ST_WAIT && tick && !neut |=> valid_r && kind_r == 2'h1)
		else $error("slice header missing");

	c_neutral_pkt: cover property (neut && state_r == lsf_pkg::ST_DATA ##1 state_r == lsf_pkg::ST_IDLE);
	c_timeout: cover property (state_r == lsf_pkg::ST_STAT);
	c_parity_fail: cover property (par_tick && par_bad);
	c_multi_slice: cover property (par_tick && !last);
endmodule // lsf_formatter
`default_nettype wire

// ---- test/link_subblock_formatter_tb_top.sv ----
// Testbench for the link sub-block formatter: register access and sub-blocks.
// Assumes the link model beside it and the params header on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "lsf_params.svh"
module link_subblock_formatter_tb_top;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic trigger_accept = 1'b0;
	logic [11:0] bunch_number = 12'h000;
	logic readout_fifo_overflow = 1'b0;
	logic module_specific_err = 1'b0;
	wire logic [31:0] hrdata, out_word;
	wire logic hreadyout, hresp, out_valid, link_data_valid_n, link_ready, tick_protocol_err;
	wire logic [19:0] link_data;
	int fails = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [31:0] got[$];
	logic [31:0] exp_q[$];
	logic [31:0] rd;
	// Expected payload word for data 1, by category code
	logic [31:0] pay_exp[1:9] = '{32'h00000001, 32'h40000001, 32'h80000001, 32'h00000001, 32'h80000001,
		32'hA0000001, 32'h40000001, 32'h60000001, 32'h50000001};

	always #20 hclk = ~hclk;

	lsf_formatter #(.TIMEOUT_CYC(16)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link_data(link_data),
		.link_data_valid_n(link_data_valid_n), .link_ready(link_ready),
		.tick_protocol_err(tick_protocol_err), .trigger_accept(trigger_accept),
		.bunch_number(bunch_number), .readout_fifo_overflow(readout_fifo_overflow),
		.module_specific_err(module_specific_err), .out_word(out_word), .out_valid(out_valid));

	lsf_link_model i_link (.hclk(hclk), .link_data(link_data), .link_data_valid_n(link_data_valid_n),
		.link_ready(link_ready), .tick_protocol_err(tick_protocol_err));

	always @(posedge hclk) begin
		if (out_valid === 1'b1) begin
			got.push_back(out_word);
		end
	end

	task automatic wrap_up();
		if (fails == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	always @(posedge hclk) begin
		cycles++;
		if (cycles == 6000) begin
			fails++;
			wrap_up();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wait_ready();
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= wr;
		hsize <= 3'h2;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		wait_ready();
		rd = hrdata;
	endtask

	task automatic trig(input logic [11:0] bn);
		@(posedge hclk);
		trigger_accept <= 1'b1;
		bunch_number <= bn;
		@(posedge hclk);
		trigger_accept <= 1'b0;
	endtask

	// Waits for the expected words, then a quiet spell for strays
	task automatic compare_out();
		int k;
		k = 0;
		while (got.size() < exp_q.size() && k < 300) begin
			@(posedge hclk);
			k++;
		end
		repeat (30) @(posedge hclk);
		check(32'(got.size()), 32'(exp_q.size()));
		foreach (exp_q[i]) begin
			if (i < got.size()) begin
				check(got[i], exp_q[i]);
			end
		end
		got.delete();
	endtask

	function automatic logic [31:0] hdr(input logic [3:0] t, input logic [2:0] f, input logic [5:0] s);
		return {t, 3'h1, f, s, 4'h5, 4'h3, 5'h00, 3'h2};
	endfunction

	function automatic logic [31:0] stat(input logic [3:0] t, input logic [5:0] b, input logic [5:0] s,
		input logic [6:0] fl);
		return {t, b, s, 4'h5, 4'h3, 1'b0, fl};
	endfunction

	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, `LSF_A_CTRL, 32'h0);
		check(rd, 32'h00000C01);
		ahb(1'b0, `LSF_A_ID, 32'h0);
		check(rd, 32'h00400001);
		ahb(1'b0, `LSF_A_PLEN, 32'h0);
		check(rd, 32'h00000004);
		ahb(1'b0, 8'h14, 32'h0);
		check(rd, 32'h00000000);
		check({31'h0, hresp}, 32'h0);
		// Formatted towers, payload word 2 dropped by mask
		ahb(1'b1, `LSF_A_ID, 32'h00400253);
		ahb(1'b1, `LSF_A_CTRL, 32'h00000C29);
		ahb(1'b1, `LSF_A_SUBS, 32'h00000004);
		ahb(1'b0, `LSF_A_CTRL, 32'h0);
		check(rd, 32'h00000C29);
		trig(12'h123);
		i_link.send_slice(12'h123, 20'h00000, 20'hABCDE, 20'h07777, 20'h12345, -1);
		i_link.send_slice(12'h1FF, 20'h00000, 20'h00000, 20'h00000, 20'h00000, 7);
		exp_q = '{hdr(`LSF_TAG_HDR, `LSF_FMT_ZS, 6'h00), 32'h400ABCDE, 32'h40012345,
			hdr(`LSF_TAG_HDR, `LSF_FMT_ZS, 6'h01), stat(4'hD, 6'h3F, 6'h01, 7'h05)};
		compare_out();
		ahb(1'b0, `LSF_A_STAT, 32'h0);
		check(rd, 32'h00000067);
		ahb(1'b1, `LSF_A_STAT, 32'h0);
		ahb(1'b0, `LSF_A_STAT, 32'h0);
		check(rd, 32'h00000040);
		// Neutral, 16-bit link, merger tags, fifo overflow
		// software picks the neutral merger tag
		ahb(1'b1, `LSF_A_CTRL, 32'h00000E00);
		readout_fifo_overflow <= 1'b1;
		trig(12'h000);
		i_link.tick(20'hFFFFF, 1'b0);
		i_link.tick(20'h12345, 1'b1);
		i_link.release_line();
		exp_q = '{hdr(`LSF_TAG_MHDR, `LSF_FMT_NEUT, 6'h00), 32'h0040FFFF, 32'h00502345,
			stat(4'hF, 6'h00, 6'h00, 7'h0A)};
		compare_out();
		readout_fifo_overflow <= 1'b0;
		// Link down and no data: timeout
		ahb(1'b1, `LSF_A_CTRL, 32'h00000C29);
		i_link.set_ready(1'b0);
		repeat (4) @(posedge hclk);
		trig(12'h055);
		exp_q = '{hdr(`LSF_TAG_HDR, `LSF_FMT_ZS, 6'h00), stat(4'hD, 6'h00, 6'h00, 7'h60)};
		compare_out();
		i_link.set_ready(1'b1);
		// Category tags 1 to 9, formatted 16-bit link, PPM sequence number 5
		ahb(1'b1, `LSF_A_ID, 32'h00450253);
		for (int c = 1; c < 10; c++) begin
			ahb(1'b1, `LSF_A_CTRL, {20'h00000, 4'hC, 4'(c), 4'h1});
			trig(12'h0AA);
			i_link.send_slice(12'h0AA, 20'h00001, 20'h00000, 20'h00000, 20'h00000, -1);
			i_link.send_slice(12'h0AA, 20'h00000, 20'h00000, 20'h00000, 20'h00000, -1);
			exp_q = '{hdr(c == 4 ? `LSF_TAG_MHDR : `LSF_TAG_HDR, `LSF_FMT_ZS, c == 1 ? 6'h05 : 6'h00),
				pay_exp[c], hdr(c == 4 ? `LSF_TAG_MHDR : `LSF_TAG_HDR, `LSF_FMT_ZS, c == 1 ? 6'h05 : 6'h01)};
			compare_out();
		end
		wrap_up();
	end
endmodule // link_subblock_formatter_tb_top
`default_nettype wire

// ---- test/lsf_link_model.sv ----
// Far-side model: serial link sender feeding the formatter's link pins.
// Assumes the same hclk as the formatter; one tick per clock.
`timescale 1ns/1ps
`default_nettype none
module lsf_link_model (
	// Clock
	input wire logic hclk,
	// Link pins
	output logic [19:0] link_data,
	output logic link_data_valid_n,
	output logic link_ready,
	output logic tick_protocol_err
);
	logic [19:0] last_d;
	initial begin
		link_data = 20'h00000;
		link_data_valid_n = 1'b1;
		link_ready = 1'b1;
		tick_protocol_err = 1'b0;
		last_d = 20'h00000;
	end
	task automatic set_ready(input logic r);
		@(posedge hclk);
		link_ready <= r;
	endtask
	task automatic tick(input logic [19:0] d, input logic pe);
		@(posedge hclk);
		link_data <= d;
		link_data_valid_n <= 1'b0;
		tick_protocol_err <= pe;
		last_d = d;
	endtask
	// Released line shows no stale data
	task automatic release_line();
		@(posedge hclk);
		link_data <= ~last_d;
		link_data_valid_n <= 1'b1;
		tick_protocol_err <= 1'b0;
	endtask
	task automatic send_slice(input logic [11:0] bn, input logic [19:0] p0, input logic [19:0] p1,
		input logic [19:0] p2, input logic [19:0] p3, input int bad_pin);
		logic [19:0] par;
		par = {8'h00, bn} ^ p0 ^ p1 ^ p2 ^ p3;
		if (bad_pin >= 0) begin
			par[bad_pin] = ~par[bad_pin];
		end
		tick({8'h00, bn}, 1'b0);
		tick(p0, 1'b0);
		tick(p1, 1'b0);
		tick(p2, 1'b0);
		tick(p3, 1'b0);
		tick(par, 1'b0);
		release_line();
	endtask
endmodule // lsf_link_model
`default_nettype wire
